// ---- cpsc_top.sv ----
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cpsc_top #(
    parameter int N_IO = 16,
    parameter logic [31:0] POL = 32'h00000000,
    // arbitrary signature value
    parameter logic [15:0] SIG = 16'h5A5A
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // user pins
    input wire logic [N_IO-1:0] io_in,
    output logic [N_IO-1:0] io_out,
    output logic [N_IO-1:0] io_oe,
    // programming pins
    input wire logic [3:0] jtag_in,
    output logic [3:0] jtag_out,
    output logic [3:0] jtag_oe,
    // power state
    output logic lp_standby,
    output logic pd_active
);
    if (N_IO < 3 || N_IO > 32) begin : g_chk
        $error("N_IO must be 3 to 32");
    end

    cpsc_pwr_if pw ();
    cpsc_isp_if ip ();

    logic [3:0] ctrl_r;
    logic [N_IO-1:0] cell_r;
    logic [N_IO-1:0] off_r;
    logic [N_IO-1:0] oe_r;
    logic [N_IO-1:0] pins_r;
    logic [N_IO-1:0] io_out_r;
    logic [3:0] jg_out_r;
    logic [3:0] jg_oe_r;
    logic [3:0] jin_r;
    logic [3:0] jtag_out_r;
    logic refused_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic addr_ok;
    logic rd_go;
    logic wr_go;
    logic wr_any;
    logic hold;
    logic [N_IO-1:0] pd_mask;
    logic [N_IO-1:0] pins_vis;
    logic [31:0] rd_word;

    cpsc_pwr u_pwr (
        .hclk(hclk),
        .hresetn(hresetn),
        .pw(pw.ctrl)
    );

    cpsc_isp u_isp (
        .hclk(hclk),
        .hresetn(hresetn),
        .ip(ip.port)
    );

    // power manager inputs
    assign pw.pd_en = ctrl_r[cpsc_pkg::CTRL_PD_EN];
    assign pw.sb_en = ctrl_r[cpsc_pkg::CTRL_SB_EN];
    assign pw.pd_a = io_in[cpsc_pkg::PD_A_PIN];
    assign pw.pd_b = io_in[cpsc_pkg::PD_B_PIN];
    assign pw.activity = (pins_vis != pins_r) || (jtag_in != jin_r)
        || (hsel && htrans[1] && hready);
    assign hold = pw.hold;
    assign lp_standby = pw.standby;
    assign pd_active = hold;

    // programming port inputs
    assign ip.en = ctrl_r[cpsc_pkg::CTRL_ISP_EN];
    assign ip.freeze = hold;
    assign ip.fuse = ctrl_r[cpsc_pkg::CTRL_FUSE];
    assign ip.tck = jtag_in[cpsc_pkg::J_TCK];
    assign ip.tms = jtag_in[cpsc_pkg::J_TMS];
    assign ip.tdi = jtag_in[cpsc_pkg::J_TDI];
    assign ip.sig = SIG;

    // power-down pins withdrawn from logic use
    assign pd_mask = ctrl_r[cpsc_pkg::CTRL_PD_EN]
        ? N_IO'(cpsc_pkg::PD_PIN_MASK) : '0;
    assign pins_vis = io_in & ~pd_mask;

    // bus decode; always zero wait and okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign addr_ok = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'b00)
        && (hsize == 3'b010);
    assign rd_go = hsel && htrans[1] && hready && !hwrite;
    assign wr_any = wr_pend_r;
    assign wr_go = wr_pend_r && !hold;

    // read mux
    always_comb begin
        rd_word = 32'h00000000;
        case (haddr[7:0])
            cpsc_pkg::REG_CTRL: rd_word = 32'(ctrl_r);
            cpsc_pkg::REG_STATUS: begin
                rd_word[cpsc_pkg::ST_HOLD] = hold;
                rd_word[cpsc_pkg::ST_STANDBY] = pw.standby;
                rd_word[cpsc_pkg::ST_LOCKED] = ip.locked;
                rd_word[cpsc_pkg::ST_FUSE] = ctrl_r[cpsc_pkg::CTRL_FUSE];
                rd_word[cpsc_pkg::ST_REFUSED] = refused_r;
                rd_word[cpsc_pkg::ST_ISP_BUSY] = ip.busy;
            end
            cpsc_pkg::REG_CELL: rd_word = 32'(cell_r);
            cpsc_pkg::REG_OFF: rd_word = 32'(off_r);
            cpsc_pkg::REG_OE: rd_word = 32'(oe_r);
            cpsc_pkg::REG_PINS: rd_word = 32'(pins_r);
            cpsc_pkg::REG_JTAG_GPIO: begin
                rd_word[cpsc_pkg::JG_OUT_LSB +: 4] = jg_out_r;
                rd_word[cpsc_pkg::JG_OE_LSB +: 4] = jg_oe_r;
                rd_word[cpsc_pkg::JG_IN_LSB +: 4] = jin_r;
            end
            cpsc_pkg::REG_SIG: rd_word = 32'(SIG);
            default: rd_word = 32'h00000000;
        endcase
        if (!addr_ok) begin
            rd_word = 32'h00000000;
        end
    end

    // address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            wr_pend_r <= hsel && htrans[1] && hready && hwrite && addr_ok;
            if (hready) begin
                wr_addr_r <= haddr[7:0];
            end
            if (rd_go) begin
                hrdata_r <= rd_word;
            end
        end
    end

    // control register; fuse can only be set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= cpsc_pkg::CTRL_RST;
        end else if (wr_any && wr_addr_r == cpsc_pkg::REG_CTRL) begin
            ctrl_r[2:0] <= hwdata[2:0];
            ctrl_r[cpsc_pkg::CTRL_FUSE] <= ctrl_r[cpsc_pkg::CTRL_FUSE]
                | hwdata[cpsc_pkg::CTRL_FUSE];
        end
    end

    // refused flag, write one clears, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refused_r <= 1'b0;
        end else if (ip.refused) begin
            refused_r <= 1'b1;
        end else if (wr_any && wr_addr_r == cpsc_pkg::REG_STATUS
                && hwdata[cpsc_pkg::ST_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // macrocell registers, frozen in power-down
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_r <= '0;
        end else if (wr_go && wr_addr_r == cpsc_pkg::REG_CELL) begin
            cell_r <= hwdata[N_IO-1:0] & ~off_r;
        end else if (wr_go && wr_addr_r == cpsc_pkg::REG_OFF) begin
            cell_r <= cell_r & ~hwdata[N_IO-1:0];
        end
    end

    // cell off mask and output enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_r <= '0;
            oe_r <= '0;
        end else if (wr_go) begin
            if (wr_addr_r == cpsc_pkg::REG_OFF) begin
                off_r <= hwdata[N_IO-1:0];
            end
            if (wr_addr_r == cpsc_pkg::REG_OE) begin
                oe_r <= hwdata[N_IO-1:0];
            end
        end
    end

    // gpio use of the programming pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jg_out_r <= 4'h0;
            jg_oe_r <= 4'h0;
        end else if (wr_go && wr_addr_r == cpsc_pkg::REG_JTAG_GPIO) begin
            jg_out_r <= hwdata[cpsc_pkg::JG_OUT_LSB +: 4];
            jg_oe_r <= hwdata[cpsc_pkg::JG_OE_LSB +: 4];
        end
    end

    // pin sampling, ignored in power-down
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_r <= '0;
            jin_r <= 4'h0;
        end else if (!hold) begin
            pins_r <= pins_vis;
            jin_r <= jtag_in;
        end
    end

    // output drivers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_out_r <= POL[N_IO-1:0];
            jtag_out_r <= 4'h0;
        end else begin
            io_out_r <= cell_r ^ POL[N_IO-1:0];
            jtag_out_r <= ctrl_r[cpsc_pkg::CTRL_ISP_EN]
                ? {ip.tdo, 3'b000} : jg_out_r;
        end
    end

    assign io_out = io_out_r;
    assign jtag_out = jtag_out_r;
    assign io_oe = oe_r & ~off_r & ~pd_mask & {N_IO{~ip.locked}};
    assign jtag_oe = ip.locked ? 4'h0
        : (ctrl_r[cpsc_pkg::CTRL_ISP_EN] ? cpsc_pkg::J_TDO_OE : jg_oe_r);

    property p_pd_enter;
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_r[cpsc_pkg::CTRL_PD_EN] && (io_in[cpsc_pkg::PD_A_PIN] || io_in[cpsc_pkg::PD_B_PIN]))
        |=> hold;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

    property p_hold_out;
        @(posedge hclk) disable iff (!hresetn)
        hold ##1 hold |=> $stable(io_out) && $stable(cell_r);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("outputs moved in power-down");

    property p_pins_frozen;
        @(posedge hclk) disable iff (!hresetn)
        hold |=> $stable(pins_r) && $stable(jin_r);
    endproperty
    a_pins_frozen: assert property (p_pins_frozen) else $error("pins sampled in power-down");

    property p_pd_pins;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_r[cpsc_pkg::CTRL_PD_EN] |-> (io_oe[1:0] == 2'b00) && (pins_vis[1:0] == 2'b00);
    endproperty
    a_pd_pins: assert property (p_pd_pins) else $error("power-down pin used as logic");

    property p_buried;
        @(posedge hclk) disable iff (!hresetn)
        (wr_go && wr_addr_r == cpsc_pkg::REG_CELL && !off_r[0])
        |=> cell_r[0] == $past(hwdata[0]);
    endproperty
    a_buried: assert property (p_buried) else $error("pd pin cell not writable");

    property p_standby;
        @(posedge hclk) disable iff (!hresetn)
        (pw.sb_en && !pw.activity)[*4] |=> lp_standby;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_cell_off;
        @(posedge hclk) disable iff (!hresetn)
        ((io_oe & off_r) == '0) && ((cell_r & off_r) == '0);
    endproperty
    a_cell_off: assert property (p_cell_off) else $error("switched-off cell active");

    property p_polarity;
        @(posedge hclk) disable iff (!hresetn)
        (cell_r == '0) |=> io_out == POL[N_IO-1:0];
    endproperty
    a_polarity: assert property (p_polarity) else $error("output not at polarity");

    property p_port_mux;
        @(posedge hclk) disable iff (!hresetn)
        (!ip.locked && !ctrl_r[cpsc_pkg::CTRL_ISP_EN]) |-> jtag_oe == jg_oe_r;
    endproperty
    a_port_mux: assert property (p_port_mux) else $error("disabled port pins not gpio");

    property p_lock_float;
        @(posedge hclk) disable iff (!hresetn)
        ip.locked |-> (io_oe == '0) && (jtag_oe == 4'h0);
    endproperty
    a_lock_float: assert property (p_lock_float) else $error("pins driven while locked");

    property p_resume;
        @(posedge hclk) disable iff (!hresetn)
        hold ##1 !hold |-> $stable(cell_r) && $stable(off_r);
    endproperty
    a_resume: assert property (p_resume) else $error("state changed on power-down exit");
endmodule
`default_nettype wire

// ---- cpsc_pkg.sv ----
// Notes on behaviour
// - with power-down enabled, either power-down input high puts the device in power-down.
// - while powered down the cell, off mask, enable and pin registers are held (control stays writable) and enabled outputs keep their value.
// - while powered down all pin transitions are ignored until the power-down input falls.
// - with power-down enabled, the power-down pins are neither logic inputs nor outputs.
// - the macrocell behind a power-down pin still works as a buried cell.
// - an optional standby mode is entered when no activity is seen and left on activity.
// - each macrocell can be switched off when the application does not use it.
// - reset clears every register but the control register (port enabled) and pattern store (erased), and each output shows the polarity of its buffer.
// - once the security fuse is set, readback of the configuration pattern is refused.
// - the sixteen-bit user signature stays readable whatever the fuse state.
// - programming uses a four-pin serial port that can be disabled to free its pins.
// - an interrupted programming cycle locks the device and floats all its pins.
package cpsc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CELL = 8'h08;
    localparam logic [7:0] REG_OFF = 8'h0C;
    localparam logic [7:0] REG_OE = 8'h10;
    localparam logic [7:0] REG_PINS = 8'h14;
    localparam logic [7:0] REG_JTAG_GPIO = 8'h18;
    localparam logic [7:0] REG_SIG = 8'h1C;
    // control fields
    localparam int CTRL_PD_EN = 0;
    localparam int CTRL_SB_EN = 1;
    localparam int CTRL_ISP_EN = 2;
    localparam int CTRL_FUSE = 3;
    localparam logic [3:0] CTRL_RST = 4'h4;
    // status fields
    localparam int ST_HOLD = 0;
    localparam int ST_STANDBY = 1;
    localparam int ST_LOCKED = 2;
    localparam int ST_FUSE = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_ISP_BUSY = 5;
    // gpio register fields of the programming pins
    localparam int JG_OUT_LSB = 0;
    localparam int JG_OE_LSB = 4;
    localparam int JG_IN_LSB = 8;
    // pin positions
    localparam int PD_A_PIN = 0;
    localparam int PD_B_PIN = 1;
    localparam int PD_PIN_MASK = 3;
    localparam int J_TCK = 0;
    localparam int J_TMS = 1;
    localparam int J_TDI = 2;
    localparam int J_TDO = 3;
    localparam logic [3:0] J_TDO_OE = 4'h8;
    // serial programming protocol
    localparam int OPC_BITS = 4;
    localparam int WORD_BITS = 16;
    localparam logic [3:0] OP_SIG = 4'h1;
    localparam logic [3:0] OP_READ = 4'h2;
    localparam logic [3:0] OP_PROG = 4'h3;
    localparam logic [15:0] PAT_ERASED = 16'hFFFF;
    // idle cycles before standby
    localparam logic [7:0] STANDBY_IDLE_CYC = 8'h04;
    typedef enum logic [1:0] {
        ISP_IDLE = 2'b00,
        ISP_OPC = 2'b01,
        ISP_DATA = 2'b10
    } cpsc_isp_st_t;
endpackage

// ---- cpsc_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// power manager hookup
interface cpsc_pwr_if;
    logic pd_en;
    logic sb_en;
    logic pd_a;
    logic pd_b;
    logic activity;
    logic hold;
    logic standby;
    modport ctrl (input pd_en, sb_en, pd_a, pd_b, activity, output hold, standby);
    modport user (output pd_en, sb_en, pd_a, pd_b, activity, input hold, standby);
endinterface

// serial programming port hookup
interface cpsc_isp_if;
    logic en;
    logic freeze;
    logic fuse;
    logic tck;
    logic tms;
    logic tdi;
    logic [15:0] sig;
    logic tdo;
    logic locked;
    logic refused;
    logic busy;
    modport port (input en, freeze, fuse, tck, tms, tdi, sig,
        output tdo, locked, refused, busy);
    modport user (output en, freeze, fuse, tck, tms, tdi, sig,
        input tdo, locked, refused, busy);
endinterface
`default_nettype wire

// ---- cpsc_pwr.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpsc_pwr (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // power control
    cpsc_pwr_if.ctrl pw
);
    logic hold_r;
    logic sb_r;
    logic [7:0] idle_r;

    assign pw.hold = hold_r;
    assign pw.standby = sb_r;

    // power-down follows either input while enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= pw.pd_en & (pw.pd_a | pw.pd_b);
        end
    end

    // idle counter, cleared by any activity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_r <= 8'h00;
        end else if (pw.activity || !pw.sb_en) begin
            idle_r <= 8'h00;
        end else if (idle_r != cpsc_pkg::STANDBY_IDLE_CYC) begin
            idle_r <= idle_r + 8'h01;
        end
    end

    // standby entry after idle run, exit on activity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sb_r <= 1'b0;
        end else begin
            sb_r <= pw.sb_en & ~pw.activity
                & (idle_r >= cpsc_pkg::STANDBY_IDLE_CYC - 8'h01);
        end
    end

    property p_sb_exit;
        @(posedge hclk) disable iff (!hresetn)
        pw.activity |=> !pw.standby;
    endproperty
    a_sb_exit: assert property (p_sb_exit) else $error("standby kept after activity");
endmodule
`default_nettype wire

// ---- cpsc_isp.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpsc_isp (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // programming port
    cpsc_isp_if.port ip
);
    cpsc_pkg::cpsc_isp_st_t st_r;
    logic tck_q_r;
    logic [3:0] opc_sh_r;
    logic [3:0] op_r;
    logic [15:0] sh_r;
    logic [15:0] pat_r;
    logic [4:0] cnt_r;
    logic lock_r;
    logic blk_r;
    logic frame;
    logic rise;
    logic [3:0] opc_now;
    logic opc_done;
    logic prog_done;
    logic prog_cut;

    // word loaded for shifting out after the opcode
    function automatic logic [15:0] load_word(input logic [3:0] op, input logic fuse,
            input logic [15:0] pat, input logic [15:0] sig);
        if (op == cpsc_pkg::OP_SIG) begin
            return sig;
        end else if (op == cpsc_pkg::OP_READ && !fuse) begin
            return pat;
        end
        return 16'h0000;
    endfunction

    assign frame = ip.en & ip.tms;
    assign rise = ip.tck & ~tck_q_r & ~ip.freeze;
    assign opc_now = {opc_sh_r[2:0], ip.tdi};
    assign opc_done = (st_r == cpsc_pkg::ISP_OPC) && frame && rise
        && (cnt_r == 5'(cpsc_pkg::OPC_BITS - 1));
    assign prog_done = (st_r == cpsc_pkg::ISP_DATA) && (op_r == cpsc_pkg::OP_PROG)
        && frame && rise && (cnt_r == 5'(cpsc_pkg::WORD_BITS - 1));
    assign prog_cut = (st_r == cpsc_pkg::ISP_DATA) && (op_r == cpsc_pkg::OP_PROG)
        && !frame && !ip.freeze && (cnt_r != 5'(cpsc_pkg::WORD_BITS));
    assign ip.tdo = sh_r[15];
    assign ip.locked = lock_r;
    assign ip.busy = (st_r != cpsc_pkg::ISP_IDLE);
    assign ip.refused = opc_done && (opc_now == cpsc_pkg::OP_READ) && ip.fuse;

    // clock edge tracker; edges during power-down are lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tck_q_r <= 1'b0;
        end else begin
            tck_q_r <= ip.tck;
        end
    end

    // frame sequencer: opcode bits, then one data word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= cpsc_pkg::ISP_IDLE;
            cnt_r <= 5'h00;
            opc_sh_r <= 4'h0;
            op_r <= 4'h0;
            sh_r <= 16'h0000;
            blk_r <= 1'b0;
        end else if (!ip.freeze) begin
            case (st_r)
                cpsc_pkg::ISP_IDLE: begin
                    if (frame) begin
                        st_r <= cpsc_pkg::ISP_OPC;
                        cnt_r <= 5'h00;
                    end
                end
                cpsc_pkg::ISP_OPC: begin
                    if (!frame) begin
                        st_r <= cpsc_pkg::ISP_IDLE;
                    end else if (rise) begin
                        opc_sh_r <= opc_now;
                        cnt_r <= cnt_r + 5'h01;
                        if (opc_done) begin
                            op_r <= opc_now;
                            st_r <= cpsc_pkg::ISP_DATA;
                            cnt_r <= 5'h00;
                            blk_r <= (opc_now == cpsc_pkg::OP_READ) && ip.fuse;
                            sh_r <= load_word(opc_now, ip.fuse, pat_r, ip.sig);
                        end
                    end
                end
                cpsc_pkg::ISP_DATA: begin
                    if (!frame) begin
                        st_r <= cpsc_pkg::ISP_IDLE;
                    end else if (rise && cnt_r != 5'(cpsc_pkg::WORD_BITS)) begin
                        sh_r <= {sh_r[14:0], (op_r == cpsc_pkg::OP_PROG) & ip.tdi};
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                default: begin
                    st_r <= cpsc_pkg::ISP_IDLE;
                end
            endcase
        end
    end

    // pattern store and lock on an interrupted program
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pat_r <= cpsc_pkg::PAT_ERASED;
            lock_r <= 1'b0;
        end else if (prog_done) begin
            pat_r <= {sh_r[14:0], ip.tdi};
            lock_r <= 1'b0;
        end else if (prog_cut) begin
            lock_r <= 1'b1;
        end
    end

    property p_refuse;
        @(posedge hclk) disable iff (!hresetn)
        (st_r == cpsc_pkg::ISP_DATA && op_r == cpsc_pkg::OP_READ && blk_r) |-> sh_r == 16'h0000;
    endproperty
    a_refuse: assert property (p_refuse) else $error("secured pattern shifted out");

    property p_sig;
        @(posedge hclk) disable iff (!hresetn)
        (opc_done && opc_now == cpsc_pkg::OP_SIG) |=> sh_r == $past(ip.sig);
    endproperty
    a_sig: assert property (p_sig) else $error("signature not loaded");

    property p_lock;
        @(posedge hclk) disable iff (!hresetn)
        prog_cut |=> lock_r && st_r == cpsc_pkg::ISP_IDLE;
    endproperty
    a_lock: assert property (p_lock) else $error("cut program did not lock");
endmodule
`default_nettype wire

// ---- cpsc_prog.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpsc_prog (
    // clock
    input wire logic hclk,
    // command
    input wire logic go,
    input wire logic [3:0] op,
    input wire logic [4:0] nbits,
    // programming pins
    input wire logic tdo,
    output logic [2:0] pins,
    // result
    output logic [15:0] rx,
    output logic done
);
    // serial clock stands still between frames
    initial begin
        pins = 3'b000;
        rx = 16'h0000;
        done = 1'b1;
    end
    // one frame: opcode msb first, then data bits while tdo is sampled
    always @(posedge go) begin
        done <= 1'b0;
        rx <= 16'h0000;
        pins <= 3'b010; // mode select high opens the frame
        for (int i = 0; i < 4 + nbits; i++) begin
            @(posedge hclk);
            if (i >= 4) rx <= {rx[14:0], tdo};
            pins[2] <= (i < 4) ? op[3 - i] : 1'b0;
            repeat (2) @(posedge hclk);
            pins[0] <= 1'b1;
            repeat (2) @(posedge hclk);
            pins[0] <= 1'b0;
        end
        @(posedge hclk);
        pins <= 3'b000;
        done <= 1'b1;
    end
endmodule
`default_nettype wire

// ---- cpsc_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpsc_top_tb;
    localparam logic [15:0] SIGV = 16'hC3A5; // arbitrary value
    logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout, lp_standby, pd_active, go, done;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] io_in, io_out, io_oe, rx;
    logic [3:0] jtag_out, jtag_oe, op;
    wire [3:0] jtag_in;
    logic [4:0] nbits;
    int num_errors = 0;
    int checks_done = 0;
    // ready loops back; undriven tdo pin shows the inverse level
    assign hready = hreadyout;
    assign jtag_in[3] = jtag_oe[3] ? jtag_out[3] : ~jtag_out[3];
    cpsc_top #(.N_IO(16), .POL(32'h00000000), .SIG(SIGV)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .jtag_in(jtag_in),
        .jtag_out(jtag_out), .jtag_oe(jtag_oe), .lp_standby(lp_standby), .pd_active(pd_active));
    cpsc_prog prog (.hclk(hclk), .go(go), .op(op), .nbits(nbits), .tdo(jtag_out[3]),
        .pins(jtag_in[2:0]), .rx(rx), .done(done));
    // verdict
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait for ready at an edge
    task automatic rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                test_done;
            end
            @(posedge hclk);
        end
    endtask
    // single word transfer, read data kept in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rdy;
        rd = hrdata;
    endtask
    // one programming frame, bounded wait for its end
    task automatic frame(input logic [3:0] o, input logic [4:0] nb);
        int n;
        op <= o;
        nbits <= nb;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1) begin
            n++;
            if (n > 400) begin
                num_errors++;
                test_done;
            end
            @(posedge hclk);
        end
        @(posedge hclk);
    endtask
    task automatic t_reset;
        check("jtag_oe", {28'h0, jtag_oe}, 32'h8);
        check("hresp", {31'h0, hresp}, 32'h0);
        check("io_oe", {16'h0, io_oe}, 32'h0);
        bus(1'b0, cpsc_pkg::REG_CTRL, 32'h0);
        check("ctrl", rd, 32'h4);
    endtask
    task automatic t_cells;
        bus(1'b1, cpsc_pkg::REG_OE, 32'hFFFF);
        bus(1'b1, cpsc_pkg::REG_CELL, 32'h00F0);
        bus(1'b1, cpsc_pkg::REG_OFF, 32'h0010);
        bus(1'b0, cpsc_pkg::REG_CELL, 32'h0);
        check("cell", rd, 32'h00E0);
        check("io_oe", {16'h0, io_oe}, 32'hFFEF);
        check("io_out", {16'h0, io_out}, 32'h00E0);
    endtask
    task automatic t_pd;
        bus(1'b1, cpsc_pkg::REG_CTRL, 32'h5);
        for (int i = 0; i < 2; i++) begin
            io_in <= 16'h0001 << i;
            repeat (2) @(posedge hclk);
            check("pd_active", {31'h0, pd_active}, 32'h1);
        end
        check("io_oe", {16'h0, io_oe}, 32'hFFEC);
        io_in <= 16'h0302;
        bus(1'b1, cpsc_pkg::REG_CELL, 32'h0A0A);
        bus(1'b0, cpsc_pkg::REG_CELL, 32'h0);
        check("cell", rd, 32'h00E0);
        check("io_out", {16'h0, io_out}, 32'h00E0);
        io_in <= 16'h0000;
        repeat (3) @(posedge hclk);
        check("pd_active", {31'h0, pd_active}, 32'h0);
        bus(1'b0, cpsc_pkg::REG_CELL, 32'h0);
        check("cell", rd, 32'h00E0);
    endtask
    task automatic t_standby;
        bus(1'b1, cpsc_pkg::REG_CTRL, 32'h6);
        repeat (7) @(posedge hclk);
        check("standby", {31'h0, lp_standby}, 32'h1);
        io_in <= 16'h0100;
        repeat (2) @(posedge hclk);
        check("standby", {31'h0, lp_standby}, 32'h0);
    endtask
    task automatic t_isp;
        bus(1'b1, cpsc_pkg::REG_CTRL, 32'h4);
        frame(cpsc_pkg::OP_SIG, 5'd16);
        check("sig", {16'h0, rx}, {16'h0, SIGV});
        frame(cpsc_pkg::OP_READ, 5'd16);
        check("pat", {16'h0, rx}, {16'h0, cpsc_pkg::PAT_ERASED});
        bus(1'b1, cpsc_pkg::REG_CTRL, 32'hC);
        frame(cpsc_pkg::OP_READ, 5'd16);
        check("pat", {16'h0, rx}, 32'h0);
        bus(1'b0, cpsc_pkg::REG_STATUS, 32'h0);
        check("refused", {31'h0, rd[4]}, 32'h1);
        frame(cpsc_pkg::OP_SIG, 5'd16);
        check("sig", {16'h0, rx}, {16'h0, SIGV});
    endtask
    task automatic t_gpio;
        bus(1'b1, cpsc_pkg::REG_CTRL, 32'h0);
        bus(1'b1, cpsc_pkg::REG_JTAG_GPIO, 32'h75);
        repeat (2) @(posedge hclk);
        check("jtag_oe", {28'h0, jtag_oe}, 32'h7);
        check("jtag_out", {28'h0, jtag_out}, 32'h5);
        bus(1'b1, cpsc_pkg::REG_CTRL, 32'h4);
        @(posedge hclk);
        check("jtag_oe", {28'h0, jtag_oe}, 32'h8);
        frame(cpsc_pkg::OP_PROG, 5'd5);
        check("jtag_oe", {28'h0, jtag_oe}, 32'h0);
        check("io_oe", {16'h0, io_oe}, 32'h0);
    endtask
    // clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // reset with inputs quiet, then the scenarios
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, io_in, go, op, nbits} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_cells;
        t_pd;
        t_standby;
        t_isp;
        t_gpio;
        test_done;
    end
    // hang guard
    initial begin
        #2000000;
        num_errors++;
        test_done;
    end
endmodule
`default_nettype wire
